/* File: verilog/orc_cmd_handler.sv */
// Recovery command parser, recovery store and output restore
`timescale 1ns/1ps
`default_nettype none
`include "orc_params.svh"

module orc_cmd_handler (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire orc_pkg::orc_byte_t rx_in,
    output logic rx_ready_out,
    output var orc_pkg::orc_byte_t tx_out,
    input wire logic tx_ready_in,
    input wire logic setting_mode_in,
    input wire logic factory_default_in,
    input wire logic power_restore_in,
    input wire logic [9:0] saved_state_in,
    input wire logic output_write_in,
    input wire logic [9:0] output_value_in,
    output logic [9:0] recovery_enable_out,
    output logic [9:0] digital_output_channels_out
);
    orc_pkg::orc_state_t state_q;
    logic [3:0] pos_q;
    logic [9:0] buf_q;
    logic bad_q;
    logic [9:0] buf_d;
    logic bad_d;
    logic [3:0] chan;
    logic take;
    logic code_take;
    logic data_take;
    logic rx_ready_q;
    logic resp_start_q;
    logic [7:0] resp_status_q;
    logic [9:0] recovery_q;
    logic [9:0] outputs_q;
    logic set_done;
    logic chk_done;
    logic commit;
    logic resp_done;
    logic mode_meta_q;
    logic mode_sync_q;

    assign take = rx_in.valid && rx_ready_q;
    assign chan = orc_pkg::orc_pos_chan(pos_q);
    assign code_take = take && state_q == orc_pkg::ORC_CODE;
    assign data_take = take && state_q == orc_pkg::ORC_SET_DATA;

    // Mode switch is asynchronous to the core clock; only the second stage is read
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            mode_meta_q <= 1'b0;
            mode_sync_q <= 1'b0;
        end else begin
            mode_meta_q <= setting_mode_in;
            mode_sync_q <= mode_meta_q;
        end
    end

    // Merge the current data byte into the pending setting
    always_comb begin
        buf_d = buf_q;
        bad_d = bad_q;
        if (chan == `ORC_NO_CHANNEL) begin
            if (rx_in.data != `ORC_SEPARATOR) begin
                bad_d = 1'b1;
            end
        end else if (rx_in.data == `ORC_VAL_ENABLE) begin
            buf_d[chan] = 1'b1;
        end else if (rx_in.data == `ORC_VAL_DISABLE) begin
            buf_d[chan] = 1'b0;
        end else begin
            bad_d = 1'b1;
        end
    end

    assign set_done = take && state_q == orc_pkg::ORC_SET_DATA && pos_q == `ORC_SET_DATA_LEN;
    assign chk_done = take && state_q == orc_pkg::ORC_CHK_DATA;
    assign commit = set_done && mode_sync_q && !bad_d;

    // Parser state: lead code, command code, then the data bytes
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_q <= orc_pkg::ORC_IDLE;
        end else if (take) begin
            case (state_q)
                orc_pkg::ORC_IDLE: begin
                    if (rx_in.data == `ORC_CODE_LEAD) begin
                        state_q <= orc_pkg::ORC_CODE;
                    end
                end
                orc_pkg::ORC_CODE: begin
                    // Extra lead bytes keep waiting for the command code
                    if (rx_in.data == `ORC_CODE_SET) begin
                        state_q <= orc_pkg::ORC_SET_DATA;
                    end else if (rx_in.data == `ORC_CODE_CHECK) begin
                        state_q <= orc_pkg::ORC_CHK_DATA;
                    end else if (rx_in.data != `ORC_CODE_LEAD) begin
                        state_q <= orc_pkg::ORC_IDLE;
                    end
                end
                orc_pkg::ORC_SET_DATA: begin
                    if (pos_q == `ORC_SET_DATA_LEN) begin
                        state_q <= orc_pkg::ORC_IDLE;
                    end
                end
                orc_pkg::ORC_CHK_DATA: begin
                    // Dummy value is not checked; any byte completes the query
                    state_q <= orc_pkg::ORC_IDLE;
                end
                default: begin
                    state_q <= orc_pkg::ORC_IDLE;
                end
            endcase
        end
    end

    // Data position restarts on every command code byte
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            pos_q <= 4'h0;
        end else if (code_take) begin
            pos_q <= 4'h1;
        end else if (data_take) begin
            pos_q <= pos_q + 4'h1;
        end
    end

    // Pending setting and its error flag, cleared by every command code byte
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            buf_q <= 10'h000;
            bad_q <= 1'b0;
        end else if (code_take) begin
            buf_q <= 10'h000;
            bad_q <= 1'b0;
        end else if (data_take) begin
            buf_q <= buf_d;
            bad_q <= bad_d;
        end
    end

    // Outcome of a set request; being outside setting mode outranks a bad byte
    function automatic logic [7:0] set_status(input logic in_mode, input logic failed);
        logic [7:0] st;
        st = `ORC_STATUS_OK;
        if (!in_mode) begin
            st = `ORC_STATUS_NOT_SETTING;
        end else if (failed) begin
            st = `ORC_SETTING_FAILED_STATUS;
        end
        return st;
    endfunction

    // Status selection and response launch
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            resp_start_q <= 1'b0;
            resp_status_q <= 8'h00;
        end else begin
            resp_start_q <= set_done || chk_done;
            if (chk_done) begin
                resp_status_q <= `ORC_STATUS_OK;
            end else if (set_done) begin
                resp_status_q <= set_status(mode_sync_q, bad_d);
            end
        end
    end

    // Intake stalls from the final request byte until the answer is sent
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rx_ready_q <= 1'b1;
        end else if (set_done || chk_done) begin
            rx_ready_q <= 1'b0;
        end else if (resp_done) begin
            rx_ready_q <= 1'b1;
        end
    end

    // Factory default takes precedence over a same-cycle commit
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            recovery_q <= `ORC_RECOVERY_RESET;
        end else if (factory_default_in) begin
            recovery_q <= `ORC_RECOVERY_RESET;
        end else if (commit) begin
            recovery_q <= buf_d;
        end
    end

    // Restore outranks a same-cycle output write
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            outputs_q <= `ORC_OUTPUT_DEFAULT;
        end else if (power_restore_in) begin
            outputs_q <= (saved_state_in & recovery_q) | (`ORC_OUTPUT_DEFAULT & ~recovery_q);
        end else if (output_write_in) begin
            outputs_q <= output_value_in;
        end
    end

    orc_resp_tx u_resp_tx (
        .clk_in(core_clk_in),
        .rst_in(rst_in),
        .start_in(resp_start_q),
        .status_in(resp_status_q),
        .enables_in(recovery_q),
        .tx_ready_in(tx_ready_in),
        .tx_out(tx_out),
        .done_out(resp_done)
    );

    assign rx_ready_out = rx_ready_q;
    assign recovery_enable_out = recovery_q;
    assign digital_output_channels_out = outputs_q;
endmodule

`default_nettype wire

/* File: shared/orc_params.svh */
// Constants for the output recovery command handler
// Overview of operation
// - A set-recovery request is the code bytes 0x31 then 0x34 followed by exactly twelve data bytes.
// - Data positions 1-4, 6-9 and 11-12 carry outputs one to ten, and positions 5 and 10 hold a 0x2C separator.
// - Each per-output byte is 0x31 for recovery enabled and 0x32 for disabled, in requests and responses alike.
// - A set request is answered with codes 0x31, 0x35 and thirteen data bytes: status then the twelve-byte layout.
// - The status byte is 0x30 when accepted, 0x31 when not in setting mode and 0x39 when the setting failed.
// - A check-recovery request is the code bytes 0x31 then 0x36 followed by one dummy byte 0x30; the handler accepts any byte as the dummy.
// - A check request gets the same response format as a set request with status always 0x30.
// - After a factory default every one of the ten outputs has recovery enabled.
`ifndef ORC_PARAMS_SVH
`define ORC_PARAMS_SVH

`define ORC_CODE_LEAD 8'h31
`define ORC_CODE_SET 8'h34
`define ORC_CODE_RESP 8'h35
`define ORC_CODE_CHECK 8'h36
`define ORC_SEPARATOR 8'h2C
`define ORC_VAL_ENABLE 8'h31
`define ORC_VAL_DISABLE 8'h32
`define ORC_STATUS_OK 8'h30
`define ORC_STATUS_NOT_SETTING 8'h31
`define ORC_SETTING_FAILED_STATUS 8'h39
`define ORC_DUMMY 8'h30
`define ORC_SET_DATA_LEN 4'hC
`define ORC_RESP_LAST_IDX 4'hE
`define ORC_RESP_HDR_LEN 4'h2
`define ORC_NO_CHANNEL 4'hF
`define ORC_RECOVERY_RESET 10'h3FF
`define ORC_OUTPUT_DEFAULT 10'h000

`endif

/* File: shared/orc_pkg.sv */
// Types and shared decode for the output recovery command handler
`include "orc_params.svh"

package orc_pkg;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } orc_byte_t;

    typedef enum logic [1:0] {
        ORC_IDLE = 2'b00,
        ORC_CODE = 2'b01,
        ORC_SET_DATA = 2'b10,
        ORC_CHK_DATA = 2'b11
    } orc_state_t;

    // Data position 1..12 to channel index, separators give no channel
    function automatic logic [3:0] orc_pos_chan(input logic [3:0] pos);
        logic [3:0] ch;
        ch = `ORC_NO_CHANNEL;
        case (pos)
            4'h1, 4'h2, 4'h3, 4'h4: ch = pos - 4'h1;
            4'h6, 4'h7, 4'h8, 4'h9: ch = pos - 4'h2;
            4'hB, 4'hC: ch = pos - 4'h3;
            default: ch = `ORC_NO_CHANNEL;
        endcase
        return ch;
    endfunction

endpackage

/* File: verilog/orc_resp_tx.sv */
// Response serializer: two code bytes, status, twelve-byte output layout
`timescale 1ns/1ps
`default_nettype none
`include "orc_params.svh"

module orc_resp_tx (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic [7:0] status_in,
    input wire logic [9:0] enables_in,
    input wire logic tx_ready_in,
    output var orc_pkg::orc_byte_t tx_out,
    output logic done_out
);
    logic busy_q;
    logic [3:0] idx_q;
    logic [7:0] status_q;
    logic [9:0] enables_q;
    orc_pkg::orc_byte_t tx_q;
    logic done_q;

    function automatic logic [7:0] byte_at(input logic [3:0] idx, input logic [7:0] st, input logic [9:0] en);
        logic [3:0] ch;
        logic [7:0] b;
        ch = orc_pkg::orc_pos_chan(idx - `ORC_RESP_HDR_LEN);
        b = `ORC_SEPARATOR;
        if (idx == 4'h0) begin
            b = `ORC_CODE_LEAD;
        end else if (idx == 4'h1) begin
            b = `ORC_CODE_RESP;
        end else if (idx == `ORC_RESP_HDR_LEN) begin
            b = st;
        end else if (ch != `ORC_NO_CHANNEL) begin
            b = en[ch] ? `ORC_VAL_ENABLE : `ORC_VAL_DISABLE;
        end
        return b;
    endfunction

    // Snapshot so a later store cannot tear a response mid-flight
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            status_q <= 8'h00;
            enables_q <= 10'h000;
        end else if (start_in && !busy_q) begin
            status_q <= status_in;
            enables_q <= enables_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            busy_q <= 1'b0;
            idx_q <= 4'h0;
            tx_q <= '0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start_in && !busy_q) begin
                busy_q <= 1'b1;
                idx_q <= 4'h0;
                tx_q.valid <= 1'b1;
                tx_q.data <= `ORC_CODE_LEAD;
            end else if (tx_q.valid && tx_ready_in) begin
                if (idx_q == `ORC_RESP_LAST_IDX) begin
                    busy_q <= 1'b0;
                    tx_q.valid <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    idx_q <= idx_q + 4'h1;
                    tx_q.data <= byte_at(idx_q + 4'h1, status_q, enables_q);
                end
            end
        end
    end

    assign tx_out = tx_q;
    assign done_out = done_q;
endmodule

`default_nettype wire

/* File: verif/orc_host_model.sv */
// Host model: sends request bytes and collects response bytes
`timescale 1ns/1ps
`default_nettype none
module orc_host_model (
    input wire logic clk_in,
    input wire logic stall_in,
    input wire logic rx_ready_in,
    output var orc_pkg::orc_byte_t rx_out,
    input wire orc_pkg::orc_byte_t tx_in,
    output logic tx_ready_out
);
    logic [7:0] q[$];
    initial begin
        rx_out = '0;
        tx_ready_out = 1'b1;
    end
    // Stalling host accepts every other cycle
    always @(negedge clk_in) tx_ready_out <= !stall_in || !tx_ready_out;
    always @(posedge clk_in) if (tx_in.valid && tx_ready_out) q.push_back(tx_in.data);
    task automatic send(input logic [7:0] b);
        @(negedge clk_in);
        rx_out = {1'b1, b};
        while (!rx_ready_in) @(negedge clk_in);
        @(posedge clk_in);
    endtask
    // Released line shows the inverted last byte, never a stale copy
    task automatic release_bus();
        @(negedge clk_in);
        rx_out = {1'b0, ~rx_out.data};
    endtask
endmodule
`default_nettype wire

/* File: verif/orc_cmd_handler_assertions.sv */
// Port checks for the recovery command handler
`timescale 1ns/1ps
`default_nettype none
module orc_cmd_handler_assertions (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire orc_pkg::orc_byte_t rx_in,
    input wire logic rx_ready_out,
    input wire orc_pkg::orc_byte_t tx_out,
    input wire logic tx_ready_in,
    input wire logic setting_mode_in,
    input wire logic factory_default_in,
    input wire logic power_restore_in,
    input wire logic [9:0] saved_state_in,
    input wire logic [9:0] recovery_enable_out,
    input wire logic [9:0] digital_output_channels_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    logic [3:0] idx_q;
    // Bytes accepted so far in the current response frame
    always_ff @(posedge core_clk_in) idx_q <= tx_out.valid ? idx_q + {3'h0, tx_ready_in} : 4'h0;
    chk_fd_all_on: assert property (factory_default_in |=> recovery_enable_out == 10'h3FF)
        else $error("not all enabled after default");
    chk_restore_out: assert property (power_restore_in |=>
        digital_output_channels_out == ($past(saved_state_in) & $past(recovery_enable_out)))
        else $error("bad restored outputs");
    chk_store_cause: assert property ($changed(recovery_enable_out) |->
        $past(factory_default_in) || $past(setting_mode_in, 3) && $past(rx_in.valid) && $past(rx_ready_out))
        else $error("settings changed without cause");
    chk_resp_launch: assert property ($fell(rx_ready_out) |=> $rose(tx_out.valid) && tx_out.data == 8'h31)
        else $error("response not launched");
    chk_status_code: assert property (tx_out.valid && idx_q == 4'h2 |->
        tx_out.data inside {8'h30, 8'h31, 8'h39})
        else $error("bad status byte");
    chk_sep_pos: assert property (tx_out.valid && (idx_q == 4'h7 || idx_q == 4'hC) |-> tx_out.data == 8'h2C)
        else $error("separator missing");
    chk_enc_bytes: assert property (tx_out.valid && idx_q > 4'h2 && idx_q != 4'h7 && idx_q != 4'hC |->
        tx_out.data inside {8'h31, 8'h32})
        else $error("bad output code");
    chk_frame_len: assert property ($fell(tx_out.valid) |-> idx_q == 4'hF)
        else $error("bad response length");
endmodule
bind orc_cmd_handler orc_cmd_handler_assertions u_chk (.core_clk_in, .rst_in, .rx_in, .rx_ready_out, .tx_out,
    .tx_ready_in, .setting_mode_in, .factory_default_in, .power_restore_in, .saved_state_in,
    .recovery_enable_out, .digital_output_channels_out);
`default_nettype wire

/* File: verif/output_recovery_cmd_handler_bench.sv */
// Self-checking bench for the recovery command handler
`timescale 1ns/1ps
`default_nettype none
module output_recovery_cmd_handler_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic mode = 1'b1, fdef = 1'b0, prst = 1'b0, owr = 1'b0, stall = 1'b0;
    logic [9:0] saved = 10'h000, oval = 10'h000, ren, dout;
    orc_pkg::orc_byte_t rx, tx;
    logic rx_rdy, tx_rdy;
    int bad_count = 0, n_tests = 0;
    orc_cmd_handler DUT (.core_clk_in(clk), .rst_in(rst), .rx_in(rx), .rx_ready_out(rx_rdy), .tx_out(tx),
        .tx_ready_in(tx_rdy), .setting_mode_in(mode), .factory_default_in(fdef), .power_restore_in(prst),
        .saved_state_in(saved), .output_write_in(owr), .output_value_in(oval), .recovery_enable_out(ren),
        .digital_output_channels_out(dout));
    orc_host_model host (.clk_in(clk), .stall_in(stall), .rx_ready_in(rx_rdy), .rx_out(rx), .tx_in(tx),
        .tx_ready_out(tx_rdy));
    initial forever #10 clk = ~clk;
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] lay(input logic [9:0] en, input int k);
        if (k == 5 || k == 10) return 8'h2C;
        return en[k < 5 ? k - 1 : k < 10 ? k - 2 : k - 3] ? 8'h31 : 8'h32;
    endfunction
    task automatic expect_resp(input logic [7:0] st, input logic [9:0] en);
        int i;
        logic [7:0] exp_b;
        for (i = 0; i < 200 && host.q.size() < 15; i++) @(posedge clk);
        for (i = 0; i < 15; i++) begin
            exp_b = i == 0 ? 8'h31 : i == 1 ? 8'h35 : i == 2 ? st : lay(en, i - 2);
            check({2'h0, host.q[i]}, {2'h0, exp_b});
        end
        host.q.delete();
        // Intake reopens once the last answer byte is gone
        repeat (2) @(negedge clk);
        check({9'h000, rx_rdy}, 10'h001);
    endtask
    // A bad position sends a code that is neither data nor separator
    task automatic set_req(input logic [9:0] en, input int bad);
        int k;
        host.send(8'h31);
        host.send(8'h34);
        for (k = 1; k <= 12; k++) host.send(k == bad ? 8'h33 : lay(en, k));
        host.release_bus();
        check({9'h000, rx_rdy}, 10'h000);
    endtask
    task automatic chk_req();
        host.send(8'h31);
        host.send(8'h36);
        host.send(8'h30);
        host.release_bus();
        check({9'h000, rx_rdy}, 10'h000);
    endtask
    task automatic pulse(input logic [2:0] v);
        @(negedge clk);
        {owr, prst, fdef} = v;
        @(negedge clk);
        {owr, prst, fdef} = 3'h0;
    endtask
    task automatic summarize();
        $display("Tests %0d, errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        check(ren, 10'h3FF);
        chk_req();
        expect_resp(8'h30, 10'h3FF);
        set_req(10'h2A5, 0);
        expect_resp(8'h30, 10'h2A5);
        check(ren, 10'h2A5);
        @(negedge clk) {stall, mode} = 2'h2;
        set_req(10'h3C3, 0);
        expect_resp(8'h31, 10'h2A5);
        @(negedge clk) mode = 1'b1;
        set_req(10'h3C3, 5);
        expect_resp(8'h39, 10'h2A5);
        // Repeated lead, then an unknown code that must drop the parser to idle
        host.send(8'h31);
        host.send(8'h31);
        host.send(8'h37);
        host.send(8'h34);
        set_req(10'h3C3, 12);
        expect_resp(8'h39, 10'h2A5);
        chk_req();
        expect_resp(8'h30, 10'h2A5);
        @(negedge clk) {oval, saved} = {10'h3FF, 10'h0F0};
        pulse(3'h4);
        check(dout, 10'h3FF);
        pulse(3'h2);
        check(dout, 10'h0A0);
        pulse(3'h1);
        check(ren, 10'h3FF);
        summarize();
    end
    initial begin
        #400000;
        bad_count++;
        summarize();
    end
endmodule
`default_nettype wire
